// ---- core/ccsb_top.sv ----
// Clock source selection, dividers and backup control registers.
`include "ccsb_defines.svh"
module ccsb_top
  import ccsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ccsb_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic xtal_option,
  input wire ccsb_osc_evt_s osc_evt,
  input wire logic hs_osc_tick,
  input wire logic ls_clk_tick,
  output ccsb_clk_ctrl_s clk_ctrl,
  output logic high_speed_clock_en,
  output logic port_output_clock_en,
  output logic sys_clk_en
);
  localparam logic [7:0] RST_DM = `CCSB_RST_DIV_MODE;
  localparam logic [7:0] RST_ES = `CCSB_RST_EN_SEL;
  localparam logic [7:0] RST_BK = `CCSB_RST_BACKUP;
  localparam logic [7:0] RST_ST = `CCSB_RST_STATUS;
  localparam ccsb_state_s RST_STATE = '{
    out_div: RST_DM[`CCSB_OUT_DIV_HI:`CCSB_OUT_DIV_LO],
    osc_mode: ccsb_osc_mode_e'(RST_DM[`CCSB_OSC_MODE_HI:`CCSB_OSC_MODE_LO]),
    hs_div: RST_DM[`CCSB_HS_DIV_HI:`CCSB_HS_DIV_LO],
    hs_en: RST_ES[`CCSB_HS_EN_BIT],
    sys_sel: RST_ES[`CCSB_SYS_SEL_BIT],
    pll_lock: RST_ES[`CCSB_PLL_LOCK_BIT],
    ls_backup: RST_BK[`CCSB_LS_BACKUP_BIT],
    hs_backup: RST_BK[`CCSB_HS_BACKUP_BIT],
    ls_fail: RST_ST[`CCSB_LS_FAIL_BIT],
    pll_fail: RST_ST[`CCSB_PLL_FAIL_BIT],
    boot: 1'b1,
    rdata: 8'h00
  };

  ccsb_state_s s_q;
  ccsb_state_s s_d;
  logic pll_active;
  logic wr_dm;
  logic wr_es;
  logic wr_bk;
  logic [7:0] img_dm;
  logic [7:0] img_es;
  logic [7:0] img_bk;
  logic [7:0] img_st;

  assign pll_active = s_q.hs_en && (s_q.osc_mode == CCSB_OSC_PLL);
  assign wr_dm = bus_req.wr && (bus_req.addr == `CCSB_ADDR_DIV_MODE);
  assign wr_es = bus_req.wr && (bus_req.addr == `CCSB_ADDR_EN_SEL);
  assign wr_bk = bus_req.wr && (bus_req.addr == `CCSB_ADDR_BACKUP);

  // Register images; every bit not named here reads as zero.
  always_comb begin
    img_dm = 8'h00;
    img_dm[`CCSB_OUT_DIV_HI:`CCSB_OUT_DIV_LO] = s_q.out_div;
    img_dm[`CCSB_OSC_MODE_HI:`CCSB_OSC_MODE_LO] = s_q.osc_mode;
    img_dm[`CCSB_HS_DIV_HI:`CCSB_HS_DIV_LO] = s_q.hs_div;
    img_es = 8'h00;
    img_es[`CCSB_PLL_LOCK_BIT] = s_q.pll_lock;
    img_es[`CCSB_HS_EN_BIT] = s_q.hs_en;
    img_es[`CCSB_SYS_SEL_BIT] = s_q.sys_sel;
    img_bk = 8'h00;
    img_bk[`CCSB_LS_BACKUP_BIT] = s_q.ls_backup;
    img_bk[`CCSB_HS_BACKUP_BIT] = s_q.hs_backup;
    img_st = 8'h00;
    img_st[`CCSB_LS_FAIL_BIT] = s_q.ls_fail;
    img_st[`CCSB_PLL_FAIL_BIT] = s_q.pll_fail;
  end

  always_comb begin
    s_d = s_q;
    s_d.boot = 1'b0;
    s_d.rdata = 8'h00;
    // The lock flag only means something while the PLL is the running source.
    s_d.pll_lock = pll_active && osc_evt.pll_locked;
    if (wr_dm) begin
      s_d.out_div = bus_req.wdata[`CCSB_OUT_DIV_HI:`CCSB_OUT_DIV_LO];
      s_d.hs_div = bus_req.wdata[`CCSB_HS_DIV_HI:`CCSB_HS_DIV_LO];
      if (!s_q.hs_en) begin
        s_d.osc_mode = ccsb_osc_mode_e'(
          bus_req.wdata[`CCSB_OSC_MODE_HI:`CCSB_OSC_MODE_LO]);
      end
    end
    if (wr_es) begin
      s_d.hs_en = bus_req.wdata[`CCSB_HS_EN_BIT];
      s_d.sys_sel = bus_req.wdata[`CCSB_SYS_SEL_BIT];
    end
    if (wr_bk && xtal_option) begin
      if (bus_req.wdata[`CCSB_LS_BACKUP_BIT]) begin
        s_d.ls_backup = 1'b0;
      end
      if (bus_req.wdata[`CCSB_HS_BACKUP_BIT]) begin
        s_d.hs_backup = 1'b0;
      end
    end
    // Hardware sets come after the software clears so an event in the
    // clearing cycle is never lost.
    if (xtal_option) begin
      if (osc_evt.ls_xtal_stop || s_q.boot) begin
        s_d.ls_backup = 1'b1;
      end
      if (pll_active && osc_evt.pll_stop) begin
        s_d.hs_backup = 1'b1;
      end
    end else begin
      s_d.ls_backup = 1'b0;
      s_d.hs_backup = 1'b0;
    end
    if (osc_evt.ls_xtal_ready) begin
      s_d.ls_fail = 1'b0;
    end
    if (osc_evt.ls_xtal_stop || osc_evt.stop_enter) begin
      s_d.ls_fail = 1'b1;
    end
    if (!pll_active || osc_evt.pll_ready) begin
      s_d.pll_fail = 1'b0;
    end
    if (pll_active && (osc_evt.pll_stop || osc_evt.stop_enter)) begin
      s_d.pll_fail = 1'b1;
    end
    // The select bit cannot hold 1 while the high-speed oscillator is off.
    if (!s_d.hs_en) begin
      s_d.sys_sel = 1'b0;
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CCSB_ADDR_DIV_MODE: s_d.rdata = img_dm;
        `CCSB_ADDR_EN_SEL: s_d.rdata = img_es;
        `CCSB_ADDR_BACKUP: s_d.rdata = img_bk;
        `CCSB_ADDR_STATUS: s_d.rdata = img_st;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  ccsb_tick_div u_hs_div (
    .clk(clk),
    .reset(reset),
    .tick_in(hs_osc_tick),
    .div_sel(s_q.hs_div),
    .tick_out(high_speed_clock_en)
  );

  ccsb_tick_div u_out_div (
    .clk(clk),
    .reset(reset),
    .tick_in(hs_osc_tick),
    .div_sel(s_q.out_div),
    .tick_out(port_output_clock_en)
  );

  assign bus_rdata = s_q.rdata;
  assign clk_ctrl.hs_osc_enable = s_q.hs_en;
  assign clk_ctrl.hs_osc_mode = s_q.osc_mode;
  assign clk_ctrl.system_clock_source_sel = s_q.sys_sel;
  assign clk_ctrl.ls_from_rc_backup = s_q.ls_backup;
  assign clk_ctrl.hs_from_rc_backup = s_q.hs_backup;
  // The system clock enable follows the select bit without retiming; the
  // selector is only safe because both sources are pulses of one clock.
  assign sys_clk_en = s_q.sys_sel ? high_speed_clock_en : ls_clk_tick;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_out_div_write: assert property (
    wr_dm |=> s_q.out_div == $past(bus_req.wdata[5:4]))
    else $error("output divider did not take the written value");

  a_mode_write: assert property (
    wr_dm && !s_q.hs_en |=> s_q.osc_mode == $past(bus_req.wdata[3:2]))
    else $error("oscillator mode did not take the written value");

  a_mode_locked: assert property (
    wr_dm && s_q.hs_en |=> $stable(s_q.osc_mode))
    else $error("oscillator mode changed while oscillation enabled");

  a_hs_div_write: assert property (
    wr_dm |=> s_q.hs_div == $past(bus_req.wdata[1:0]))
    else $error("high-speed divider did not take the written value");

  a_hs_div_pulse: assert property (
    s_q.hs_div == 2'h3 && hs_osc_tick && $stable(s_q.hs_div)
    |-> ##1 !high_speed_clock_en || !$past(high_speed_clock_en, 2))
    else $error("divide by eight produced back to back pulses");

  a_lock_needs_pll: assert property (
    !pll_active |=> !s_q.pll_lock)
    else $error("lock flag set without an active PLL");

  a_enable_write: assert property (
    wr_es |=> s_q.hs_en == $past(bus_req.wdata[1]))
    else $error("oscillation enable did not take the written value");

  a_sel_forced: assert property (
    !clk_ctrl.hs_osc_enable |-> !clk_ctrl.system_clock_source_sel
    && (sys_clk_en == ls_clk_tick))
    else $error("system clock not on low-speed while oscillator off");

  a_backup_inert: assert property (
    !xtal_option |=> !s_q.ls_backup && !s_q.hs_backup)
    else $error("backup flag set without crystal option");

  a_ls_backup_set: assert property (
    xtal_option && osc_evt.ls_xtal_stop |=> s_q.ls_backup)
    else $error("crystal stop did not enter low-speed backup");

  a_ls_cancel: assert property (
    xtal_option && wr_bk && bus_req.wdata[2] && !osc_evt.ls_xtal_stop
    && !s_q.boot |=> !s_q.ls_backup)
    else $error("low-speed backup not cancelled by writing one");

  a_ls_zero_write: assert property (
    wr_bk && !bus_req.wdata[2] && s_q.ls_backup && xtal_option
    |=> s_q.ls_backup)
    else $error("writing zero changed the low-speed backup flag");

  a_hs_backup_set: assert property (
    xtal_option && pll_active && osc_evt.pll_stop
    |=> s_q.hs_backup ##0 s_q.pll_fail)
    else $error("PLL stop did not enter high-speed backup");

  a_hs_cancel: assert property (
    xtal_option && wr_bk && bus_req.wdata[1]
    && !(pll_active && osc_evt.pll_stop) |=> !s_q.hs_backup)
    else $error("high-speed backup not cancelled by writing one");

  a_hs_backup_hold: assert property (
    xtal_option && s_q.hs_backup && !(wr_bk && bus_req.wdata[1])
    |=> s_q.hs_backup)
    else $error("high-speed backup flag dropped without a cancel");

  a_boot_backup: assert property (
    s_q.boot && xtal_option |=> s_q.ls_backup)
    else $error("crystal option did not start in low-speed backup");

  a_ls_fail_set: assert property (
    osc_evt.stop_enter || osc_evt.ls_xtal_stop |=> s_q.ls_fail)
    else $error("crystal status not set on stop");

  a_pll_fail_clear: assert property (
    !pll_active |=> !s_q.pll_fail)
    else $error("PLL status set while PLL disabled");

  a_status_read: assert property (
    bus_req.rd && bus_req.addr == `CCSB_ADDR_STATUS
    |=> bus_rdata == {5'h00, $past(s_q.ls_fail), $past(s_q.pll_fail), 1'b0})
    else $error("status read returned wrong image");

  a_status_ro: assert property (
    bus_req.wr && bus_req.addr == `CCSB_ADDR_STATUS
    && !osc_evt.stop_enter && !osc_evt.ls_xtal_stop
    && !osc_evt.ls_xtal_ready |=> $stable(s_q.ls_fail))
    else $error("write to status register changed it");

  a_reserved_zero: assert property (
    bus_req.rd && bus_req.addr == `CCSB_ADDR_DIV_MODE
    |=> bus_rdata[7:6] == 2'h0)
    else $error("reserved bits read non-zero");

  a_rdata_one_cycle: assert property (
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data present without a read");

  c_ls_cancel: cover property (
    s_q.ls_backup && wr_bk && bus_req.wdata[2] ##1 !s_q.ls_backup);
  c_hs_cancel: cover property (
    s_q.hs_backup && wr_bk && bus_req.wdata[1] ##1 !s_q.hs_backup);
  c_mode_blocked: cover property (wr_dm && s_q.hs_en);
  c_pll_locked: cover property (pll_active ##1 s_q.pll_lock);
endmodule

// ---- common/ccsb_defines.svh ----
// Offsets, field positions and reset values of the clock source control block.
// What this block does
// - Output clock divider field: 00 /1, 01 /2, 10 /4, 11 /8; reset /8.
// - Oscillator mode field: 00 RC, 10 PLL; 01 and 11 unused; reset RC.
// - Oscillator mode writes take effect only while high-speed oscillation is off.
// - High-speed clock divider field: 00 /1, 01 /2, 10 /4, 11 /8; reset /8.
// - Read-only PLL lock flag in bit 7; zero when PLL inactive; resets 0.
// - High-speed oscillation enable bit stops or runs oscillator; resets to 1.
// - System clock select: 0 low-speed, 1 divided high-speed; resets to 1.
// - With oscillation disabled, clock select is forced 0 and low-speed runs.
// - Backup register works only with the crystal option; otherwise inert.
// - Low-speed backup flag bit 2 is 1 while RC backup replaces crystal.
// - Writing 1 to low-speed backup flag returns to crystal, clears flag.
// - High-speed backup flag bit 1: crystal option, PLL mode, PLL stopped.
// - Writing 1 to high-speed backup flag returns to PLL, clears flag.
// - High-speed backup flag stays set after STOP release until cancelled.
// - With crystal option the block starts in low-speed backup after power-up.
// - Crystal status sets at power-up, crystal stop and STOP entry.
// - PLL status sets on PLL stop or STOP entry while PLL active; 0 while PLL runs or is inactive.
// - Status is read-only, resets 04H; control registers reset 33H, 03H, 00H.
// - Status bit 2 is crystal status, bit 1 PLL status, others zero.
`ifndef CCSB_DEFINES_SVH
`define CCSB_DEFINES_SVH
`define CCSB_ADDR_W 16
`define CCSB_DATA_W 8
`define CCSB_ADDR_DIV_MODE 16'hF002
`define CCSB_ADDR_EN_SEL 16'hF003
`define CCSB_ADDR_BACKUP 16'hF005
`define CCSB_ADDR_STATUS 16'hF00A
`define CCSB_RST_DIV_MODE 8'h33
`define CCSB_RST_EN_SEL 8'h03
`define CCSB_RST_BACKUP 8'h00
`define CCSB_RST_STATUS 8'h04
`define CCSB_OUT_DIV_HI 5
`define CCSB_OUT_DIV_LO 4
`define CCSB_OSC_MODE_HI 3
`define CCSB_OSC_MODE_LO 2
`define CCSB_HS_DIV_HI 1
`define CCSB_HS_DIV_LO 0
`define CCSB_PLL_LOCK_BIT 7
`define CCSB_HS_EN_BIT 1
`define CCSB_SYS_SEL_BIT 0
`define CCSB_LS_BACKUP_BIT 2
`define CCSB_HS_BACKUP_BIT 1
`define CCSB_LS_FAIL_BIT 2
`define CCSB_PLL_FAIL_BIT 1
`define CCSB_DIV_CNT_W 3
`endif

// ---- common/ccsb_pkg.sv ----
// Types shared by the clock source control block.
package ccsb_pkg;
  typedef enum logic [1:0] {
    CCSB_OSC_RC = 2'b00,
    CCSB_OSC_RSV1 = 2'b01,
    CCSB_OSC_PLL = 2'b10,
    CCSB_OSC_RSV3 = 2'b11
  } ccsb_osc_mode_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccsb_bus_req_s;

  // Events from the analog oscillators and the power controller.
  typedef struct packed {
    logic ls_xtal_stop;
    logic ls_xtal_ready;
    logic pll_stop;
    logic pll_ready;
    logic pll_locked;
    logic stop_enter;
  } ccsb_osc_evt_s;

  typedef struct packed {
    logic hs_osc_enable;
    ccsb_osc_mode_e hs_osc_mode;
    logic system_clock_source_sel;
    logic ls_from_rc_backup;
    logic hs_from_rc_backup;
  } ccsb_clk_ctrl_s;

  typedef struct packed {
    logic [1:0] out_div;
    ccsb_osc_mode_e osc_mode;
    logic [1:0] hs_div;
    logic hs_en;
    logic sys_sel;
    logic pll_lock;
    logic ls_backup;
    logic hs_backup;
    logic ls_fail;
    logic pll_fail;
    logic boot;
    logic [7:0] rdata;
  } ccsb_state_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } ccsb_div_state_s;
endpackage

// ---- core/ccsb_tick_div.sv ----
// Divides an enable pulse train by 1, 2, 4 or 8.
`include "ccsb_defines.svh"
module ccsb_tick_div
  import ccsb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tick_in,
  input wire logic [1:0] div_sel,
  output logic tick_out
);
  ccsb_div_state_s q;
  ccsb_div_state_s d;
  logic [2:0] mask;

  always_comb begin
    case (div_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // A divider change mid-count takes effect on the next input tick, because the
  // compare applies the new mask to the current count, so that period can end early.
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (tick_in) begin
      d.cnt = q.cnt + 3'h1;
      if ((q.cnt & mask) == mask) begin
        d.tick = 1'b1;
        d.cnt = 3'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule

// ---- test/test_clock_source_select_backup.sv ----
// Self-checking bench for the clock source control block.
`include "ccsb_defines.svh"
module test_clock_source_select_backup
  import ccsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0] EV_LSTOP = 6'h20;
  localparam logic [5:0] EV_LRDY = 6'h10;
  localparam logic [5:0] EV_PSTOP = 6'h08;
  localparam logic [5:0] EV_PRDY = 6'h04;
  localparam logic [5:0] EV_STOP = 6'h01;
  logic clk;
  logic reset;
  ccsb_bus_req_s bus_req;
  logic [7:0] bus_rdata;
  logic xtal_option;
  ccsb_osc_evt_s osc_evt;
  logic hs_osc_tick;
  logic ls_clk_tick;
  ccsb_clk_ctrl_s clk_ctrl;
  logic high_speed_clock_en;
  logic port_output_clock_en;
  logic sys_clk_en;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  ccsb_top u_ccsb_top (
    .clk(clk),
    .reset(reset),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .xtal_option(xtal_option),
    .osc_evt(osc_evt),
    .hs_osc_tick(hs_osc_tick),
    .ls_clk_tick(ls_clk_tick),
    .clk_ctrl(clk_ctrl),
    .high_speed_clock_en(high_speed_clock_en),
    .port_output_clock_en(port_output_clock_en),
    .sys_clk_en(sys_clk_en)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends one step after the edge that took the write, so effects are settled.
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    check(what, d, exp);
  endtask

  task automatic ev(input logic [5:0] m);
    @(posedge clk);
    osc_evt <= osc_evt | m;
    @(posedge clk);
    osc_evt <= osc_evt & ~m;
    #1;
  endtask

  task automatic do_reset(input logic x);
    @(posedge clk);
    reset <= 1'b1;
    xtal_option <= x;
    osc_evt <= '0;
    bus_req <= '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic t_reset();
    rd_chk("div_mode", `CCSB_ADDR_DIV_MODE, 8'h33);
    rd_chk("en_sel", `CCSB_ADDR_EN_SEL, 8'h03);
    rd_chk("backup", `CCSB_ADDR_BACKUP, 8'h00);
    rd_chk("status", `CCSB_ADDR_STATUS, 8'h04);
    rd_chk("unmapped", 16'hF004, 8'h00);
    bus_wr(`CCSB_ADDR_STATUS, 8'hFF);
    rd_chk("status ro", `CCSB_ADDR_STATUS, 8'h04);
    ev(EV_LSTOP);
    rd_chk("backup inert", `CCSB_ADDR_BACKUP, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_boot();
    rd_chk("boot backup", `CCSB_ADDR_BACKUP, 8'h04);
    check("ls rc", {7'h0, clk_ctrl.ls_from_rc_backup}, 8'h01);
    bus_wr(`CCSB_ADDR_BACKUP, 8'h00);
    rd_chk("w0 backup", `CCSB_ADDR_BACKUP, 8'h04);
    ev(EV_LRDY);
    rd_chk("xtal ok", `CCSB_ADDR_STATUS, 8'h00);
    bus_wr(`CCSB_ADDR_BACKUP, 8'h04);
    rd_chk("ls cancel", `CCSB_ADDR_BACKUP, 8'h00);
    check("ls rc off", {7'h0, clk_ctrl.ls_from_rc_backup}, 8'h00);
    ev(EV_LSTOP);
    rd_chk("ls stop", `CCSB_ADDR_BACKUP, 8'h04);
    rd_chk("ls fail", `CCSB_ADDR_STATUS, 8'h04);
    ev(EV_LRDY);
    bus_wr(`CCSB_ADDR_BACKUP, 8'h04);
    ev(EV_PSTOP);
    rd_chk("hs rc mode", `CCSB_ADDR_BACKUP, 8'h00);
    rd_chk("pll rc mode", `CCSB_ADDR_STATUS, 8'h00);
    $display("test boot done");
  endtask

  task automatic t_mode();
    bus_wr(`CCSB_ADDR_DIV_MODE, 8'h08);
    rd_chk("mode locked", `CCSB_ADDR_DIV_MODE, 8'h00);
    bus_wr(`CCSB_ADDR_EN_SEL, 8'h00);
    check("osc en", {7'h0, clk_ctrl.hs_osc_enable}, 8'h00);
    @(posedge clk);
    ls_clk_tick <= 1'b1;
    #1 check("sys ls", {7'h0, sys_clk_en}, 8'h01);
    @(posedge clk);
    ls_clk_tick <= 1'b0;
    bus_wr(`CCSB_ADDR_EN_SEL, 8'h01);
    rd_chk("sel forced", `CCSB_ADDR_EN_SEL, 8'h00);
    check("sel out", {7'h0, clk_ctrl.system_clock_source_sel},
          8'h00);
    for (int m = 0; m < 4; m++) begin
      bus_wr(`CCSB_ADDR_DIV_MODE, {4'h0, 2'(m), 2'b00});
      rd_chk("mode code", `CCSB_ADDR_DIV_MODE, {4'h0, 2'(m), 2'b00});
    end
    bus_wr(`CCSB_ADDR_DIV_MODE, 8'hFB);
    rd_chk("rsv div", `CCSB_ADDR_DIV_MODE, 8'h3B);
    check("pll mode", 8'(clk_ctrl.hs_osc_mode), 8'h02);
    bus_wr(`CCSB_ADDR_EN_SEL, 8'hFF);
    rd_chk("rsv en", `CCSB_ADDR_EN_SEL, 8'h03);
    check("sel on", {7'h0, clk_ctrl.system_clock_source_sel},
          8'h01);
    $display("test mode done");
  endtask

  task automatic t_pll();
    logic [7:0] d;
    @(posedge clk);
    osc_evt.pll_locked <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("lock", `CCSB_ADDR_EN_SEL, 8'h83);
    ev(EV_PSTOP);
    rd_chk("hs backup", `CCSB_ADDR_BACKUP, 8'h02);
    check("hs rc", {7'h0, clk_ctrl.hs_from_rc_backup}, 8'h01);
    rd_chk("pll fail", `CCSB_ADDR_STATUS, 8'h02);
    ev(EV_PRDY);
    ev(EV_STOP);
    rd_chk("stop fail", `CCSB_ADDR_STATUS, 8'h06);
    bus_wr(`CCSB_ADDR_BACKUP, 8'h00);
    bus_rd(`CCSB_ADDR_BACKUP, d);
    check("hs after stop", {7'h0, d[1]}, 8'h01);
    ev(EV_PRDY);
    ev(EV_LRDY);
    rd_chk("all ok", `CCSB_ADDR_STATUS, 8'h00);
    bus_wr(`CCSB_ADDR_BACKUP, 8'h06);
    rd_chk("hs cancel", `CCSB_ADDR_BACKUP, 8'h00);
    check("hs rc off", {7'h0, clk_ctrl.hs_from_rc_backup}, 8'h00);
    $display("test pll done");
  endtask

  // Sixty-four ticks hold a whole number of periods of every ratio, so the
  // pulse count does not depend on where the divider counters stand.
  task automatic t_div();
    int n_hs;
    int n_out;
    int n_bad;
    for (int c = 0; c < 4; c++) begin
      n_hs = 0;
      n_out = 0;
      n_bad = 0;
      bus_wr(`CCSB_ADDR_DIV_MODE, {2'b00, 2'(c), 2'b10, 2'(3 - c)});
      @(posedge clk);
      hs_osc_tick <= 1'b1;
      for (int i = 0; i < 65; i++) begin
        @(posedge clk);
        if (i == 63) begin
          hs_osc_tick <= 1'b0;
        end
        #1;
        n_hs += int'(high_speed_clock_en);
        n_out += int'(port_output_clock_en);
        n_bad += int'(sys_clk_en !== high_speed_clock_en);
      end
      check("out div", 8'(n_out), 8'(64 >> c));
      check("hs div", 8'(n_hs), 8'(64 >> (3 - c)));
      check("sys hs", 8'(n_bad), 8'h00);
    end
    $display("test div done");
  endtask

  initial begin
    reset = 1'b1;
    bus_req = '0;
    xtal_option = 1'b0;
    osc_evt = '0;
    hs_osc_tick = 1'b0;
    ls_clk_tick = 1'b0;
    do_reset(1'b0);
    t_reset();
    do_reset(1'b1);
    t_boot();
    t_mode();
    t_pll();
    t_div();
    tally_and_finish();
  end
endmodule
